/* rtl/pbdc_pkg.sv */
/*
  Package for the bridge device control register block: offset, field
  positions, reset values, size encodings and the carrier structs.
  Assumes a single core clock and a configuration-space access port.
*/
package pbdc_pkg;

  // ==========================================================================
  // Register placement and reset
  // ==========================================================================
  localparam logic [11:0] PBDC_DEVCTL_OFFSET = 12'h098;
  localparam logic [15:0] PBDC_DEVCTL_RESET  = 16'h2800;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int PBDC_RETRY_BIT   = 15;
  localparam int PBDC_RRS_LSB     = 12;
  localparam int PBDC_NOSNOOP_BIT = 11;
  localparam int PBDC_AUXPM_BIT   = 10;
  localparam int PBDC_PHANTOM_BIT = 9;
  localparam int PBDC_EXTTAG_BIT  = 8;
  localparam int PBDC_PAY_LSB     = 5;
  localparam int PBDC_RELAX_BIT   = 4;
  localparam int PBDC_URR_BIT     = 3;
  localparam int PBDC_FATAL_BIT   = 2;
  localparam int PBDC_NONFAT_BIT  = 1;
  localparam int PBDC_CORR_BIT    = 0;

  // ==========================================================================
  // Field reset values and largest size code
  // ==========================================================================
  localparam logic [2:0] PBDC_RRS_RESET     = 3'h2;
  localparam logic [2:0] PBDC_PAY_RESET     = 3'h0;
  localparam logic       PBDC_NOSNOOP_RESET = 1'b1;
  localparam logic [2:0] PBDC_SIZE_MAX_CODE = 3'h5;

  // Size codes 0..5 map to 128 << code bytes; bytes held as 13-bit counts.
  localparam logic [12:0] PBDC_SIZE_BASE  = 13'h0080;
  localparam logic [12:0] PBDC_CACHE_UNIT = 13'h0004;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic        req;
    logic        wr;
    logic [11:0] addr;
    logic [15:0] wdata;
    logic [1:0]  be;
  } pbdc_cfg_req_s;

  typedef struct packed {
    logic        hit;
    logic [15:0] rdata;
  } pbdc_cfg_rsp_s;

  typedef struct packed {
    logic unsupported_req;
    logic fatal_evt;
    logic nonfatal_evt;
    logic correctable_evt;
  } pbdc_err_evt_s;

  typedef struct packed {
    logic msg_fatal;
    logic msg_nonfatal;
    logic msg_correctable;
  } pbdc_err_msg_s;

  typedef struct packed {
    logic        retry_en;
    logic [2:0]  rrs;
    logic        nosnoop;
    logic [2:0]  pay;
    logic        urr;
    logic        fatal;
    logic        nonfatal;
    logic        corr;
    logic [15:0] rdata;
    logic        hit;
    pbdc_err_msg_s msg;
  } pbdc_state_s;

endpackage

/* rtl/pbdc_device_control.sv */
/*
  Device control register of the bridge with the control effects it
  drives: retry completion decision, read request and payload limits,
  upstream no-snoop attribute and error message gating.
  Assumes configuration accesses and events arrive synchronous to clock;
  aux_rst_b is the auxiliary-power-domain reset, asserted only on loss
  of auxiliary power.
*/
`timescale 1ns/10ps
`default_nettype none

// Function
// - With retry enable set, a timed-out forwarded configuration access gets a retry-status completion.
// - With retry enable clear, no retry-status completion is ever produced, and the bit resets to zero.
// - The read request size code selects 128 to 4096 bytes, codes six and seven are reserved, reset selects 512.
// - Read fetch length combines the read request limit with the cache line size and never exceeds the limit.
// - The payload size code selects 128 to 4096 bytes, codes six and seven are reserved, reset selects 128.
// - No posted write or read completion is started with a payload above the selected payload size.
// - No-snoop enable, reset one, sets the no-snoop attribute on upstream memory traffic on channels other than zero.
// - The aux power enable bit is read/write, resets to zero and steers nothing.
// - The aux power enable bit is sticky and survives ordinary reset while on auxiliary power.
// - Phantom function, extended tag and relaxed ordering enables read zero and ignore writes.
// - With unsupported request reporting set, an unsupported request sends a nonfatal message.
// - Fatal messages go out on a system error event only while fatal reporting is set, reset zero.
// - Nonfatal messages go out on a system error event only while nonfatal reporting is set, reset zero.
// - Correctable messages go out on a system error event only while correctable reporting is set, reset zero.
// - The sixteen-bit register sits at offset 98h and holds 2800h after reset.
module pbdc_device_control (
  input  wire logic                   clock,          // Core clock, 25 MHz.
  input  wire logic                   rst_b,          // Synchronous reset, active low.
  input  wire logic                   aux_rst_b,      // Aux-domain reset, active low.
  input  wire pbdc_pkg::pbdc_cfg_req_s cfg_req,       // Configuration access.
  output var  pbdc_pkg::pbdc_cfg_rsp_s cfg_rsp,       // Read data and hit, one cycle later.
  input  wire logic                   cfg_timeout,    // Forwarded config access timed out.
  output logic                        retry_cpl,      // Return retry-status completion.
  input  wire logic [7:0]             cache_line_dw,  // Cache line size in dwords.
  input  wire logic [12:0]            read_req_len,   // Requested read length in bytes.
  output logic [12:0]                 read_fetch_len, // Bytes a read request fetches.
  input  wire logic [12:0]            payload_len,    // Proposed payload length in bytes.
  output logic                        payload_ok,     // Payload may be started.
  input  wire logic                   up_mem_nonvc0,  // Upstream memory TLP on channel above zero.
  output logic                        no_snoop_attr,  // No-snoop attribute for that TLP.
  input  wire pbdc_pkg::pbdc_err_evt_s err_evt,       // Error event pulses.
  output var  pbdc_pkg::pbdc_err_msg_s err_msg,       // Error message requests, registered.
  output logic [2:0]                  read_request_size_limit, // Current read request code.
  output logic [2:0]                  payload_size_limit       // Current payload code.
);
  import pbdc_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  pbdc_state_s s_q;
  pbdc_state_s s_d;
  logic        aux_power_pm_enable_q;
  logic        wr_hit;
  logic        lo_we;
  logic        hi_we;
  logic [15:0] reg_view;
  logic [12:0] rrs_bytes;
  logic [12:0] pay_bytes;
  logic [12:0] line_bytes;
  logic [12:0] fetch;

  function automatic logic [12:0] size_bytes(input logic [2:0] code);
    logic [2:0] c;
    c = (code > PBDC_SIZE_MAX_CODE) ? PBDC_SIZE_MAX_CODE : code;
    return PBDC_SIZE_BASE << c;
  endfunction

  assign wr_hit = cfg_req.req && cfg_req.wr && (cfg_req.addr == PBDC_DEVCTL_OFFSET);
  assign lo_we  = wr_hit && cfg_req.be[0];
  assign hi_we  = wr_hit && cfg_req.be[1];

  always_comb begin
    reg_view = 16'h0000;
    reg_view[PBDC_RETRY_BIT]                  = s_q.retry_en;
    reg_view[PBDC_RRS_LSB +: 3]               = s_q.rrs;
    reg_view[PBDC_NOSNOOP_BIT]                = s_q.nosnoop;
    reg_view[PBDC_AUXPM_BIT]                  = aux_power_pm_enable_q;
    reg_view[PBDC_PAY_LSB +: 3]               = s_q.pay;
    reg_view[PBDC_URR_BIT]                    = s_q.urr;
    reg_view[PBDC_FATAL_BIT]                  = s_q.fatal;
    reg_view[PBDC_NONFAT_BIT]                 = s_q.nonfatal;
    reg_view[PBDC_CORR_BIT]                   = s_q.corr;
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    s_d = s_q;
    if (hi_we) begin
      s_d.retry_en = cfg_req.wdata[PBDC_RETRY_BIT];
      s_d.rrs      = cfg_req.wdata[PBDC_RRS_LSB +: 3];
      s_d.nosnoop  = cfg_req.wdata[PBDC_NOSNOOP_BIT];
    end
    if (lo_we) begin
      s_d.pay      = cfg_req.wdata[PBDC_PAY_LSB +: 3];
      s_d.urr      = cfg_req.wdata[PBDC_URR_BIT];
      s_d.fatal    = cfg_req.wdata[PBDC_FATAL_BIT];
      s_d.nonfatal = cfg_req.wdata[PBDC_NONFAT_BIT];
      s_d.corr     = cfg_req.wdata[PBDC_CORR_BIT];
    end
    s_d.hit   = cfg_req.req && !cfg_req.wr && (cfg_req.addr == PBDC_DEVCTL_OFFSET);
    s_d.rdata = s_d.hit ? reg_view : 16'h0000;
    // Unsupported requests travel as nonfatal messages when reported.
    s_d.msg.msg_fatal       = err_evt.fatal_evt && s_q.fatal;
    s_d.msg.msg_nonfatal    = (err_evt.nonfatal_evt && s_q.nonfatal) ||
                              (err_evt.unsupported_req && s_q.urr);
    s_d.msg.msg_correctable = err_evt.correctable_evt && s_q.corr;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_q          <= '0;
      s_q.rrs      <= PBDC_RRS_RESET;
      s_q.nosnoop  <= PBDC_NOSNOOP_RESET;
      s_q.pay      <= PBDC_PAY_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Sticky bit lives in the aux domain so an ordinary reset leaves it alone.
  always_ff @(posedge clock) begin
    if (!aux_rst_b) begin
      aux_power_pm_enable_q <= 1'b0;
    end else if (hi_we) begin
      aux_power_pm_enable_q <= cfg_req.wdata[PBDC_AUXPM_BIT];
    end
  end

  // ==========================================================================
  // Control effects
  // ==========================================================================
  assign retry_cpl = cfg_timeout && s_q.retry_en;

  // Reserved codes saturate to 4096 bytes rather than wrap.
  assign rrs_bytes  = size_bytes(s_q.rrs);
  assign pay_bytes  = size_bytes(s_q.pay);
  assign line_bytes = (cache_line_dw == 8'h00) ? rrs_bytes :
                      13'({5'h00, cache_line_dw} * PBDC_CACHE_UNIT);

  // Fetch rounds up to one cache line, then clamps to the read limit.
  always_comb begin
    fetch = (read_req_len < line_bytes) ? line_bytes : read_req_len;
    if (fetch > rrs_bytes) begin
      fetch = rrs_bytes;
    end
  end
  assign read_fetch_len = fetch;

  assign payload_ok    = (payload_len <= pay_bytes);
  assign no_snoop_attr = up_mem_nonvc0 && s_q.nosnoop;

  assign cfg_rsp.hit   = s_q.hit;
  assign cfg_rsp.rdata = s_q.rdata;
  assign err_msg       = s_q.msg;
  assign read_request_size_limit = s_q.rrs;
  assign payload_size_limit      = s_q.pay;

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_retry;
    @(posedge clock) disable iff (!rst_b) retry_cpl |-> cfg_timeout && s_q.retry_en;
  endproperty
  a_retry: assert property (p_retry) else $error("retry completion while disabled");

  property p_retry_on;
    @(posedge clock) disable iff (!rst_b) (cfg_timeout && s_q.retry_en) |-> retry_cpl;
  endproperty
  a_retry_on: assert property (p_retry_on) else $error("timed-out access not retried");

  // Checked against the plain shift, so a broken size decode cannot hide behind itself.
  property p_fetch;
    @(posedge clock) disable iff (!rst_b)
      (s_q.rrs <= PBDC_SIZE_MAX_CODE) |-> (read_fetch_len <= (PBDC_SIZE_BASE << s_q.rrs));
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch above read limit");

  property p_pay;
    @(posedge clock) disable iff (!rst_b)
      (payload_ok && (s_q.pay <= PBDC_SIZE_MAX_CODE)) |-> (payload_len <= (PBDC_SIZE_BASE << s_q.pay));
  endproperty
  a_pay: assert property (p_pay) else $error("payload above limit");

  property p_reset;
    @(posedge clock)
      (!rst_b && !hi_we && (!aux_rst_b || !aux_power_pm_enable_q)) |=> reg_view == PBDC_DEVCTL_RESET;
  endproperty
  a_reset: assert property (p_reset) else $error("reset value wrong");

  property p_ro;
    @(posedge clock) disable iff (!rst_b)
      reg_view[PBDC_PHANTOM_BIT] == 1'b0 && reg_view[PBDC_EXTTAG_BIT] == 1'b0 && reg_view[PBDC_RELAX_BIT] == 1'b0;
  endproperty
  a_ro: assert property (p_ro) else $error("read-only bit set");

  property p_sticky;
    @(posedge clock) disable iff (!aux_rst_b) (!rst_b && !hi_we) |=> $stable(aux_power_pm_enable_q);
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky bit lost on reset");

  property p_fatal;
    @(posedge clock) disable iff (!rst_b) err_msg.msg_fatal |-> $past(err_evt.fatal_evt) && $past(s_q.fatal);
  endproperty
  a_fatal: assert property (p_fatal) else $error("fatal message while disabled");

  sequence s_fatal_evt;
    err_evt.fatal_evt && s_q.fatal;
  endsequence

  property p_fatal_on;
    @(posedge clock) disable iff (!rst_b) s_fatal_evt |=> err_msg.msg_fatal;
  endproperty
  a_fatal_on: assert property (p_fatal_on) else $error("fatal message missing");

  sequence s_nonfat_evt;
    err_evt.nonfatal_evt && s_q.nonfatal;
  endsequence

  property p_nonfat_on;
    @(posedge clock) disable iff (!rst_b) s_nonfat_evt |=> err_msg.msg_nonfatal;
  endproperty
  a_nonfat_on: assert property (p_nonfat_on) else $error("nonfatal message missing");

  sequence s_corr_evt;
    err_evt.correctable_evt && s_q.corr;
  endsequence

  property p_corr;
    @(posedge clock) disable iff (!rst_b) s_corr_evt |=> err_msg.msg_correctable;
  endproperty
  a_corr: assert property (p_corr) else $error("correctable message missing");

  sequence s_ur_evt;
    err_evt.unsupported_req && s_q.urr;
  endsequence

  property p_ur;
    @(posedge clock) disable iff (!rst_b) s_ur_evt |=> err_msg.msg_nonfatal;
  endproperty
  a_ur: assert property (p_ur) else $error("unsupported request not reported");

  property p_nonfat;
    @(posedge clock) disable iff (!rst_b)
      err_msg.msg_nonfatal |-> ($past(err_evt.nonfatal_evt) && $past(s_q.nonfatal)) ||
                               ($past(err_evt.unsupported_req) && $past(s_q.urr));
  endproperty
  a_nonfat: assert property (p_nonfat) else $error("nonfatal message while disabled");

  property p_snoop;
    @(posedge clock) disable iff (!rst_b) no_snoop_attr == (up_mem_nonvc0 && reg_view[PBDC_NOSNOOP_BIT]);
  endproperty
  a_snoop: assert property (p_snoop) else $error("no-snoop set wrongly");

endmodule
`default_nettype wire

/* bench/pbdc_root_model.sv */
/*
  Root complex model: counts the error messages and retry-status
  completions that the bridge sends upstream.
  Assumes one core clock and message pulses that stand one cycle.
*/
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Message sink
// ==========================================================================
module pbdc_root_model (
  input  wire logic                    clock,     // Core clock.
  input  wire logic                    rst_b,     // Sync reset, active low.
  input  wire pbdc_pkg::pbdc_err_msg_s msg,       // Error messages.
  input  wire logic                    retry_cpl, // Retry-status completion.
  output var  int                      n_fatal,   // Fatal messages seen.
  output var  int                      n_nonfat,  // Nonfatal messages seen.
  output var  int                      n_corr,    // Correctable messages seen.
  output var  int                      n_retry    // Retry completions seen.
);
  import pbdc_pkg::*;
  // Each pulse is one message, so a pulse held two cycles counts twice.
  always @(posedge clock) begin
    if (!rst_b) begin
      n_fatal <= 0;
      n_nonfat <= 0;
      n_corr <= 0;
      n_retry <= 0;
    end else begin
      n_fatal <= n_fatal + int'(msg.msg_fatal);
      n_nonfat <= n_nonfat + int'(msg.msg_nonfatal);
      n_corr <= n_corr + int'(msg.msg_correctable);
      n_retry <= n_retry + int'(retry_cpl);
    end
  end
endmodule
`default_nettype wire

/* bench/pbdc_device_control_tb.sv */
/*
  Testbench of the device control register: register model, limits,
  attributes and message gating compared with the design.
  Assumes the root complex model beside it and a 25 MHz core clock.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module pbdc_device_control_tb;
  import pbdc_pkg::*;
  logic          clock, rst_b, aux_rst_b, tmo, nonvc0, pok, rty, nsa;
  pbdc_cfg_req_s req;
  pbdc_cfg_rsp_s rsp;
  pbdc_err_evt_s evt;
  pbdc_err_msg_s msg, xm;
  logic [7:0]    cl;
  logic [12:0]   rlen, flen, plen;
  logic [2:0]    rrs_o, pay_o;
  logic [15:0]   m;
  int            n_mismatch, check_count, cyc, seed, nf, nn, nc, nr, ef, en, ec, er;

  pbdc_device_control pbdc_device_control_i (.clock(clock), .rst_b(rst_b), .aux_rst_b(aux_rst_b),
    .cfg_req(req), .cfg_rsp(rsp), .cfg_timeout(tmo), .retry_cpl(rty), .cache_line_dw(cl),
    .read_req_len(rlen), .read_fetch_len(flen), .payload_len(plen), .payload_ok(pok),
    .up_mem_nonvc0(nonvc0), .no_snoop_attr(nsa), .err_evt(evt), .err_msg(msg),
    .read_request_size_limit(rrs_o), .payload_size_limit(pay_o));
  pbdc_root_model pbdc_root_model_i (.clock(clock), .rst_b(rst_b), .msg(msg), .retry_cpl(rty),
    .n_fatal(nf), .n_nonfat(nn), .n_corr(nc), .n_retry(nr));

  // ==========================================================================
  // Clock, timeout and verdict
  // ==========================================================================
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      end_of_test;
    end
  end

  // ==========================================================================
  // Configuration accesses
  // ==========================================================================
  task wr(input logic [15:0] d, input logic [1:0] b);
    logic [15:0] k;
    k = {{8{b[1]}}, {8{b[0]}}} & 16'hFCEF;
    @(negedge clock);
    req = '{1'b1, 1'b1, 12'h098, d, b};
    @(negedge clock);
    req.req = 1'b0;
    m = (m & ~k) | (d & k);
  endtask
  task rd(input logic [11:0] a);
    @(negedge clock);
    req = '{1'b1, 1'b0, a, 16'h0000, 2'h3};
    @(negedge clock);
    req.req = 1'b0;
    `CHK(rsp.hit, a == 12'h098)
    `CHK(rsp.rdata, (a == 12'h098) ? m : 16'h0000)
  endtask

  // ==========================================================================
  // Random control traffic
  // ==========================================================================
  task rnd;
    int r, p, lp, lim, f;
    r = {$random(seed)} % 6;
    p = {$random(seed)} % 6;
    wr((16'($random(seed)) & 16'h8F1F) | 16'(r << 12) | 16'(p << 5), 2'h3);
    @(negedge clock);
    cl = 8'($random(seed));
    rlen = 13'($random(seed));
    tmo = 1'($random(seed));
    nonvc0 = 1'($random(seed));
    evt = 4'($random(seed));
    lp = 128 << p;
    plen = 13'(lp - 1 + {$random(seed)} % 3);
    lim = 128 << r;
    f = (cl * 4 > rlen) ? cl * 4 : rlen;
    if (f > lim || cl == 0) f = lim;
    xm = {evt.fatal_evt & m[2], (evt.nonfatal_evt & m[1]) | (evt.unsupported_req & m[3]),
          evt.correctable_evt & m[0]};
    er += int'(tmo & m[15]);
    ef += int'(xm.msg_fatal);
    en += int'(xm.msg_nonfatal);
    ec += int'(xm.msg_correctable);
    #5;
    `CHK(rrs_o, 3'(r))
    `CHK(pay_o, 3'(p))
    `CHK(flen, 13'(f))
    `CHK(pok, plen <= lp)
    `CHK(rty, tmo & m[15])
    `CHK(nsa, nonvc0 & m[11])
    @(negedge clock);
    `CHK(msg, xm)
    evt = '0;
    tmo = 1'b0;
  endtask

  initial begin
    seed = 16787;
    rst_b = 1'b0;
    aux_rst_b = 1'b0;
    req = '0;
    evt = '0;
    tmo = 1'b0;
    nonvc0 = 1'b0;
    cl = 8'h00;
    rlen = 13'h0000;
    plen = 13'h0000;
    m = 16'h2800;
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    aux_rst_b = 1'b1;
    rd(12'h098);
    rd(12'h09A);
    $display("test reset done");
    wr(16'hDFBF, 2'h3);
    rd(12'h098);
    wr(16'h0000, 2'h1);
    rd(12'h098);
    $display("test access done");
    // The aux bit must outlive a core reset but not an aux-domain reset.
    wr(16'h0400, 2'h2);
    @(negedge clock);
    rst_b = 1'b0;
    @(negedge clock);
    rst_b = 1'b1;
    m = 16'h2C00;
    rd(12'h098);
    @(negedge clock);
    rst_b = 1'b0;
    aux_rst_b = 1'b0;
    @(negedge clock);
    rst_b = 1'b1;
    aux_rst_b = 1'b1;
    m = 16'h2800;
    rd(12'h098);
    $display("test aux done");
    repeat (60) rnd;
    repeat (2) @(negedge clock);
    `CHK(nr, er)
    `CHK(nf, ef)
    `CHK(nn, en)
    `CHK(nc, ec)
    $display("test traffic done");
    end_of_test;
  end
endmodule
`default_nettype wire
